/* File: design/baud_gen.sv */
/*
 * Baud rate generator with protocol gating, interrupt routing and wake
 * requests. Assumes one 40 MHz clock; the external serial clock and the
 * programmable clock arrive as levels slower than a third of mclk_i.
 */
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "baud_gen_map.svh"

module baud_gen (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic nrst_i,
	// Register bus
	input wire baud_gen_pkg::avmm_req_type bus_req_i,
	output baud_gen_pkg::avmm_rsp_type bus_rsp_o,
	// Clock sources and serial function events
	input wire logic prog_clk_i,
	input wire logic ext_sck_i,
	input wire logic func_irq_i,
	input wire logic func_busy_i,
	// Outputs toward receiver, transmitter and system
	output baud_gen_pkg::baud_out_type baud_o,
	output logic shared_irq_o,
	output logic clk_request_o
);
	import baud_gen_pkg::*;

	// ==========================================================
	// Registers
	logic [1:0] proto_reg, proto_next;
	logic [4:0] mode_reg, mode_next;
	logic [15:0] div_reg, div_next;
	bus_state_type bst_reg, bst_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [2:0] sync_reg, sync_next;
	logic [2:0] psync_reg, psync_next;
	logic [2:0] mdiv_reg, mdiv_next;
	logic [15:0] cnt_reg, cnt_next;
	logic [3:0] ovs_reg, ovs_next;
	logic samp_reg, samp_next;
	logic baud_reg, baud_next;
	logic irq_reg, irq_next;
	logic req_reg, req_next;

	logic func_on, src_tick, over8, wake_en;
	logic [3:0] ovs_last;

	// Edge of a synchronised level; only stages two and three are read
	function automatic logic rise(input logic now, input logic prev);
		rise = now & ~prev;
	endfunction

	assign func_on = (proto_reg == `PROTO_SERIAL);
	assign over8 = mode_reg[`POS_OVER];
	assign wake_en = mode_reg[`POS_WAKE];
	assign ovs_last = over8 ? `OVER8_LAST : `OVER16_LAST;

	// ==========================================================
	// Bus slave: one wait state, then answer. Read data are loaded on
	// entry to the answer cycle so that they stand while waitrequest is
	// low; a write lands at the edge that ends the answer cycle.
	always_comb begin
		bst_next = bst_reg;
		rdata_next = rdata_reg;
		proto_next = proto_reg;
		mode_next = mode_reg;
		div_next = div_reg;
		case (bst_reg)
			bus_idle: begin
				if (bus_req_i.read || bus_req_i.write) begin
					bst_next = bus_done;
				end
				// Capture read data now, shown during the answer cycle
				if (bus_req_i.read) begin
					case (bus_req_i.address)
						`OFS_PARENT_MODE: rdata_next = {30'h0, proto_reg};
						`OFS_SERIAL_MODE: rdata_next = {27'h0, mode_reg};
						`OFS_BAUD_GEN: rdata_next = {16'h0, div_reg};
						`OFS_STATUS: rdata_next = {29'h0, req_reg, irq_reg,
							func_on};
						default: rdata_next = 32'h0000_0000;
					endcase
				end
			end
			bus_done: begin
				bst_next = bus_idle;
				if (bus_req_i.write) begin
					case (bus_req_i.address)
						`OFS_PARENT_MODE: proto_next = bus_req_i.writedata[1:0];
						`OFS_SERIAL_MODE: mode_next = bus_req_i.writedata[4:0];
						`OFS_BAUD_GEN: div_next = bus_req_i.writedata[15:0];
						default: ;
					endcase
				end
			end
			default: bst_next = bus_idle;
		endcase
	end

	// Waitrequest drops in the answer cycle; read data come from flops
	always_comb begin
		bus_rsp_o.waitrequest = (bst_reg != bus_done);
		bus_rsp_o.readdata = rdata_reg;
	end

	// ==========================================================
	// Source selection. Both slow clocks pass two flops before use; the
	// third flop only holds the previous level for edge detection, so a
	// metastable first stage never reaches the divider.
	always_comb begin
		sync_next = {sync_reg[1:0], ext_sck_i};
		psync_next = {psync_reg[1:0], prog_clk_i};
		mdiv_next = mdiv_reg + 3'h1;
		case (mode_reg[1:0])
			`SEL_MAIN: src_tick = 1'b1;
			`SEL_MAIN_DIV: src_tick = (mdiv_reg == `MAIN_DIV_COUNT);
			`SEL_PROG: src_tick = rise(psync_reg[1], psync_reg[2]);
			`SEL_EXT: src_tick = rise(sync_reg[1], sync_reg[2]);
			default: src_tick = 1'b0;
		endcase
	end

	// ==========================================================
	// Divider and oversampling: divisor pulses form the sampling clock,
	// then every 8th or 16th sample gives the shared baud pulse
	always_comb begin
		cnt_next = cnt_reg;
		ovs_next = ovs_reg;
		samp_next = 1'b0;
		baud_next = 1'b0;
		if (!func_on || div_reg == 16'h0000) begin
			cnt_next = 16'h0000;
			ovs_next = 4'h0;
		end else if (src_tick) begin
			if (div_reg == 16'h0001 || cnt_reg >= div_reg - 16'h0001) begin
				cnt_next = 16'h0000;
				samp_next = 1'b1;
				if (ovs_reg >= ovs_last) begin
					ovs_next = 4'h0;
					baud_next = 1'b1;
				end else begin
					ovs_next = ovs_reg + 4'h1;
				end
			end else begin
				cnt_next = cnt_reg + 16'h0001;
			end
		end
	end

	// Interrupt routing and clock request
	always_comb begin
		irq_next = func_on & func_irq_i;
		req_next = wake_en & func_busy_i;
	end

	always_comb begin
		baud_o.sample_pulse = samp_reg;
		baud_o.baud_pulse = baud_reg;
		baud_o.func_clk_en = func_on;
		shared_irq_o = irq_reg;
		clk_request_o = req_reg;
	end

	// ==========================================================
	// State registers
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			proto_reg <= 2'h0;
			mode_reg <= 5'h00;
			div_reg <= `RST_DIVISOR;
			bst_reg <= bus_idle;
			rdata_reg <= 32'h0000_0000;
			sync_reg <= 3'h0;
			psync_reg <= 3'h0;
			mdiv_reg <= 3'h0;
			cnt_reg <= 16'h0000;
			ovs_reg <= 4'h0;
			samp_reg <= 1'b0;
			baud_reg <= 1'b0;
			irq_reg <= 1'b0;
			req_reg <= 1'b0;
		end else begin
			proto_reg <= proto_next;
			mode_reg <= mode_next;
			div_reg <= div_next;
			bst_reg <= bst_next;
			rdata_reg <= rdata_next;
			sync_reg <= sync_next;
			psync_reg <= psync_next;
			mdiv_reg <= mdiv_next;
			cnt_reg <= cnt_next;
			ovs_reg <= ovs_next;
			samp_reg <= samp_next;
			baud_reg <= baud_next;
			irq_reg <= irq_next;
			req_reg <= req_next;
		end
	end

endmodule // baud_gen
`default_nettype wire

/* File: inc/baud_gen_map.svh */
/*
 * Register offsets, field positions, reset values and fixed counts of the
 * baud rate generator. Assumes a 32-bit Avalon-MM slave, word addressed by
 * byte address bits [3:2].
 */
// Contract
// - Stop serial clock unless protocol select is 1
// - Route interrupts only when protocol select is 1
// - Request peripheral clock when wake enabled
// - One baud clock shared by receiver and transmitter
// - Source select picks one of four clocks
// - Divide source by 16-bit clock divisor
// - Divisor zero gives no clock
// - Divisor one bypasses the divider
// - Divisor output samples; divide by 16 or 8
// - Oversample bit set gives 8x, clear 16x
// - Baud equals source over 8*(2-over)*divisor
// - Source select 3 chooses external serial clock
`ifndef BAUD_GEN_MAP_SVH
`define BAUD_GEN_MAP_SVH

// ==========================================================
// Register byte offsets
`define OFS_PARENT_MODE 4'h0
`define OFS_SERIAL_MODE 4'h4
`define OFS_BAUD_GEN 4'h8
`define OFS_STATUS 4'hc

// ==========================================================
// Field positions and values
`define PROTO_SERIAL 2'h1
`define SEL_MAIN 2'h0
`define SEL_MAIN_DIV 2'h1
`define SEL_PROG 2'h2
`define SEL_EXT 2'h3
`define POS_SEL 0
`define POS_OVER 2
`define POS_CLOCK_OUTPUT_ENABLE 3
`define POS_WAKE 4

// ==========================================================
// Reset values and fixed counts
`define RST_DIVISOR 16'h0000
`define MAIN_DIV_COUNT 3'h7
`define OVER8_LAST 4'h7
`define OVER16_LAST 4'hf

`endif

/* File: inc/baud_gen_pkg.sv */
/*
 * Types of the baud rate generator. Assumes baud_gen_map.svh for numbers.
 */
package baud_gen_pkg;

	// Avalon-MM request from the master
	typedef struct packed {
		logic [3:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} avmm_req_type;

	// Avalon-MM answer to the master
	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} avmm_rsp_type;

	// Clocks handed to receiver and transmitter
	typedef struct packed {
		logic sample_pulse;
		logic baud_pulse;
		logic func_clk_en;
	} baud_out_type;

	// Bus slave state
	typedef enum logic [0:0] {
		bus_idle,
		bus_done
	} bus_state_type;

endpackage

/* File: sim/baud_gen_assertions.sv */
/* Port checker of baud_gen, bound at the foot of this file.
   Assumes fields change only through accepted bus writes. */
`timescale 1ns/10ps
`default_nettype none
`include "baud_gen_map.svh"
module baud_gen_assertions import baud_gen_pkg::*; (
	// Clock, reset, bus
	input wire logic mclk_i, nrst_i,
	input wire avmm_req_type bus_req_i,
	input wire avmm_rsp_type bus_rsp_o,
	// Sources and events
	input wire logic prog_clk_i, ext_sck_i, func_irq_i, func_busy_i,
	// Results
	input wire baud_out_type baud_o,
	input wire logic shared_irq_o, clk_request_o
);
	logic [15:0] div_q, gap;
	logic [1:0] proto_q, sel_q, off;
	logic wake_q, seen;
	wire wr = bus_req_i.write && !bus_rsp_o.waitrequest;
	wire [31:0] wd = bus_req_i.writedata;
	wire [3:0] ad = bus_req_i.address;
	// Shadow fields; seen drops on writes since the divider may restart
	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			{div_q, gap, proto_q, sel_q, wake_q, seen} <= '0;
			off <= 2'h3;
		end else begin
			off <= {off[0], proto_q != `PROTO_SERIAL};
			gap <= baud_o.sample_pulse ? 16'h0 : gap + 16'h1;
			seen <= !wr && (seen || baud_o.sample_pulse);
			if (wr && ad == `OFS_PARENT_MODE) proto_q <= wd[1:0];
			if (wr && ad == `OFS_SERIAL_MODE) wake_q <= wd[`POS_WAKE];
			if (wr && ad == `OFS_SERIAL_MODE) sel_q <= wd[1:0];
			if (wr && ad == `OFS_BAUD_GEN) div_q <= wd[15:0];
		end
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	sequence baud_quiet; !baud_o.baud_pulse [*7]; endsequence
	clk_stop_a: assert property (&off && proto_q != `PROTO_SERIAL |->
		!baud_o.func_clk_en && !baud_o.sample_pulse) else $error("gated");
	irq_block_a: assert property (&off |-> !shared_irq_o)
		else $error("irq leaks");
	irq_pass_a: assert property (!(|off) && func_irq_i
		&& $past(func_irq_i) |-> shared_irq_o) else $error("irq lost");
	wake_req_a: assert property (clk_request_o |-> wake_q
		|| $past(wake_q)) else $error("request without wake");
	zero_div_a: assert property (div_q == 16'h0 &&
		$past(div_q, 4) == 16'h0 |-> !baud_o.sample_pulse) else $error("div0");
	div_gap_a: assert property (baud_o.sample_pulse && seen &&
		sel_q == `SEL_MAIN && div_q != 16'h0 |-> gap == div_q - 16'h1)
		else $error("sample spacing");
	baud_src_a: assert property (baud_o.baud_pulse |->
		baud_o.sample_pulse || $past(baud_o.sample_pulse)) else $error("src");
	baud_gap_a: assert property (baud_o.baud_pulse |=> baud_quiet)
		else $error("baud too close");
endmodule // baud_gen_assertions
bind baud_gen baud_gen_assertions chk (.mclk_i, .nrst_i, .bus_req_i,
	.bus_rsp_o, .prog_clk_i, .ext_sck_i, .func_irq_i, .func_busy_i,
	.baud_o, .shared_irq_o, .clk_request_o);
`default_nettype wire

/* File: sim/baud_gen_test.sv */
/* Self-checking bench of baud_gen: pulse counts against a model.
   Assumes the checker binds itself. */
`timescale 1ns/10ps
`default_nettype none
`include "baud_gen_map.svh"
module baud_gen_test;
	import baud_gen_pkg::*;
	logic mclk_i = 0, nrst_i = 0, irq = 0, busy = 0, run = 0;
	logic prog_clk_i, ext_sck_i, shared_irq_o, clk_request_o;
	avmm_req_type req = '0;
	avmm_rsp_type rsp;
	baud_out_type baud_o;
	int miscompares = 0, n_compared = 0, d, ov;
	logic [31:0] rd;
	always #12.5 mclk_i = !mclk_i;
	baud_gen DUT (.mclk_i, .nrst_i, .bus_req_i(req), .bus_rsp_o(rsp),
		.prog_clk_i, .ext_sck_i, .func_irq_i(irq), .func_busy_i(busy),
		.baud_o, .shared_irq_o, .clk_request_o);
	sck_peer #(.HALF(4)) peer (.mclk_i, .run_i(run), .sck_o(ext_sck_i));
	sck_peer #(.HALF(4)) programmable_clock (.mclk_i, .run_i(1'b1), .sck_o(prog_clk_i));
	// ==========================================================
	// Tasks
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g, int t);
		n_compared++;
		if ($isunknown(g) || g + t < e || g > e + t) begin
			miscompares++;
			$display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	// Request held until waitrequest is seen low at an edge
	task automatic bus(logic w, logic [3:0] a, logic [31:0] v = 0);
		@(posedge mclk_i);
		req <= '{a, !w, w, v};
		do @(posedge mclk_i); while (rsp.waitrequest !== 1'b0);
		rd = rsp.readdata;
		req <= '0;
	endtask
	task automatic cfg(int p, int s, int w, int div);
		@(posedge mclk_i);
		run <= s == 3;
		busy <= w[0];
		d = div;
		ov = $urandom % 2;
		bus(1, `OFS_PARENT_MODE, p);
		bus(1, `OFS_SERIAL_MODE, s | ov << `POS_OVER | w << `POS_WAKE);
		bus(1, `OFS_BAUD_GEN, div);
	endtask
	// Model: src events over d, then over 8*(2-ov) for the baud clock
	task automatic win(string nm, int src, int t);
		int s = 0, b = 0;
		repeat (1600) begin
			@(negedge mclk_i);
			s += baud_o.sample_pulse;
			b += baud_o.baud_pulse;
		end
		chk({nm, " samples"}, d ? src / d : 0, s, t);
		chk({nm, " bauds"}, d ? src / d / (8 * (2 - ov)) : 0, b, t);
		$display("test %s done", nm);
	endtask
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Watchdog well beyond the planned 16k cycles
	initial begin
		repeat (60000) @(posedge mclk_i);
		miscompares++;
		wrap_up;
	end
	initial begin
		void'($urandom(32'h797b83ef));
		repeat (12) @(posedge mclk_i);
		nrst_i <= 1'b1;
		irq <= 1'b1;
		for (int p = 0; p < 4; p++) begin
			cfg(p, 0, 0, 3);
			win("protocol", p == 1 ? 1600 : 0, 2);
			chk("irq", p == 1, shared_irq_o, 0);
			chk("clk enable", p == 1, baud_o.func_clk_en, 0);
		end
		for (int s = 0; s < 4; s++) begin
			cfg(1, s, 0, s ? 2 + $urandom % 3 : 3 + $urandom % 3);
			win("source", s ? 200 : 1600, 2);
		end
		cfg(1, 0, 0, 0);
		win("zero", 1600, 0);
		cfg(1, 0, 0, 1);
		win("bypass", 1600, 2);
		bus(0, `OFS_BAUD_GEN);
		chk("divisor", 1, rd[15:0], 0);
		for (int w = 1; w >= 0; w--) begin
			cfg(1, 0, w, 5);
			repeat (4) @(negedge mclk_i);
			chk("clk request", w, clk_request_o, 0);
		end
		wrap_up;
	end
endmodule // baud_gen_test
`default_nettype wire

/* File: sim/sck_peer.sv */
/* Far-side serial clock source, reused as the slow programmable clock.
   Assumes run_i changes only between frames. */
`timescale 1ns/10ps
`default_nettype none
module sck_peer #(parameter int HALF = 4) (
	input wire logic mclk_i,
	input wire logic run_i,
	output logic sck_o = 1'b0
);
	int n = 0;
	// Phases of HALF cycles; idle low so no stray edge between frames
	always @(posedge mclk_i) begin
		n <= run_i ? (n + 1) % HALF : 0;
		if (!run_i) sck_o <= 1'b0;
		else if (n == HALF - 1) sck_o <= !sck_o;
	end
endmodule // sck_peer
`default_nettype wire
